// file: shared/eemc_defines.vh
// Constants of the EEPROM mode controller.
`ifndef EEMC_DEFINES_VH
`define EEMC_DEFINES_VH
`define EEMC_CLK_MHZ 40
`define EEMC_CLK_NS 25
`define EEMC_ADDR_W 10
`define EEMC_DATA_W 8
`define EEMC_OP_US 1000
`define EEMC_OP_CYC (`EEMC_OP_US * `EEMC_CLK_MHZ)
`define EEMC_VPSU_US 5
`define EEMC_VPSU_CYC (`EEMC_VPSU_US * `EEMC_CLK_MHZ)
`define EEMC_ACC_NS 650
`define EEMC_ACC_CYC ((`EEMC_ACC_NS + `EEMC_CLK_NS - 1) / `EEMC_CLK_NS)
`define EEMC_SU_NS 200
`define EEMC_SU_CYC ((`EEMC_SU_NS + `EEMC_CLK_NS - 1) / `EEMC_CLK_NS)
`define EEMC_CMD_READ 2'h0
`define EEMC_CMD_ERASE 2'h1
`define EEMC_CMD_PROG 2'h2
`endif

// file: verilog/eemc_timer.v
// Down counter that pulses done when a loaded delay expires.
`timescale 1ns/1ps
`default_nettype none
module eemc_timer #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire load,
  input wire [W-1:0] count,
  output reg done
);
  reg [W-1:0] cnt_reg;
  reg busy_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {W{1'b0}};
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_reg <= count;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/eemc_host.v
// Host controller that drives the EEPROM pins for read, erase, program.
// Contract
// [R1] Three modes; erase/program only at VPP.
// [R2] Erase clears every bit to zero.
// [R3] Program only turns zeros into ones.
// [R4] Address latched on enable fall; data held.
// [R5] Device drives data only for read combination.
// [R6] Erase: enables high, raise VPP, pulse OE.
// [R7] Device floats outputs while at VPP.
// [R8] Program: enables high, raise VPP, pulse CE.
// [R9] Address valid at CE fall; data whole pulse.
// [R10] Many programs follow erase without dropping VPP.
// [R11] Both enables high during supply transitions.
// [R12] Ten address lines select 1024 bytes.
// [R13] Eight bidirectional three-state data lines.
// [R14] Low chip select disables outputs normally.
// [R15] High OE disables; low OE at VPP erases.
// [R16] Low CE at VPP programs latched address.
// [R17] Erase and program each take 1 msec.
// [R18] Never both enables low at VPP.
// [R19] Program is OR into stored byte.
`include "eemc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module eemc_host #(
  parameter AW = `EEMC_ADDR_W,
  parameter DW = `EEMC_DATA_W,
  parameter OP_CYC = `EEMC_OP_CYC,
  parameter VPSU_CYC = `EEMC_VPSU_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire cmd_hold_vpp,
  input wire [AW-1:0] cmd_addr,
  input wire [DW-1:0] cmd_wdata,
  output reg cmd_ready,
  output reg rsp_valid,
  output reg [DW-1:0] rsp_rdata,
  // Device pins
  output reg [AW-1:0] address_lines,
  input wire [DW-1:0] data_io_lines_i,
  output reg [DW-1:0] data_io_lines_o,
  output reg data_io_lines_oe,
  output reg chip_enable_n,
  output reg output_enable_n,
  output reg chip_select,
  output reg vpp_enable
);
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_ACCESS = 3'h2;
  localparam S_VPP_UP = 3'h3;
  localparam S_PULSE = 3'h4;
  localparam S_VPP_DN = 3'h5;
  localparam S_DONE = 3'h6;
  localparam TW = 16;
  localparam integer SU_I = `EEMC_SU_CYC;
  localparam integer ACC_I = `EEMC_ACC_CYC;
  reg [2:0] state_reg;
  reg [1:0] op_reg;
  reg hold_reg;
  reg [DW-1:0] din_meta_reg;
  reg [DW-1:0] din_sync_reg;
  reg tload;
  reg [TW-1:0] tcount;
  wire tdone;
  eemc_timer #(.W(TW)) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_reg <= {DW{1'b0}};
      din_sync_reg <= {DW{1'b0}};
    end else begin
      din_meta_reg <= data_io_lines_i;
      din_sync_reg <= din_meta_reg;
    end
  end
  always @* begin
    tload = 1'b0;
    tcount = {TW{1'b0}};
    if (state_reg == S_IDLE && cmd_valid) begin
      tload = 1'b1;
      if (cmd_op == `EEMC_CMD_READ) begin
        tcount = SU_I[TW-1:0];
      end else if (vpp_enable) begin
        tcount = SU_I[TW-1:0];
      end else begin
        tcount = VPSU_CYC[TW-1:0];
      end
    end else if (state_reg == S_SETUP && tdone) begin
      tload = 1'b1;
      tcount = OP_CYC[TW-1:0];
      if (op_reg == `EEMC_CMD_READ) begin
        tcount = ACC_I[TW-1:0];
      end
    end else if (state_reg == S_VPP_UP && tdone) begin
      tload = 1'b1;
      tcount = OP_CYC[TW-1:0];
    end else if (state_reg == S_PULSE && tdone) begin
      tload = 1'b1;
      tcount = SU_I[TW-1:0];
    end else if (state_reg == S_VPP_DN && tdone && !hold_reg) begin
      tload = 1'b1;
      tcount = VPSU_CYC[TW-1:0];
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      op_reg <= `EEMC_CMD_READ;
      hold_reg <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {DW{1'b0}};
      address_lines <= {AW{1'b0}};
      data_io_lines_o <= {DW{1'b0}};
      data_io_lines_oe <= 1'b0;
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      chip_select <= 1'b0;
      vpp_enable <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            op_reg <= cmd_op;
            hold_reg <= cmd_hold_vpp;
            address_lines <= cmd_addr; // R12
            if (cmd_op == `EEMC_CMD_READ) begin
              chip_select <= 1'b1;
              state_reg <= vpp_enable ? S_VPP_DN : S_SETUP;
            end else begin
              chip_select <= 1'b0;
              if (cmd_op == `EEMC_CMD_PROG) begin
                data_io_lines_o <= cmd_wdata; // R9
                data_io_lines_oe <= 1'b1; // R13
              end
              vpp_enable <= 1'b1; // R1 R6 R8 R11
              state_reg <= vpp_enable ? S_SETUP : S_VPP_UP; // R10
            end
          end
        end
        S_VPP_UP: begin
          if (tdone) begin
            state_reg <= S_PULSE;
            if (op_reg == `EEMC_CMD_ERASE) begin
              output_enable_n <= 1'b0; // R6 R15 R2
            end else begin
              chip_enable_n <= 1'b0; // R8 R16 R3 R19
            end
          end
        end
        S_SETUP: begin
          if (tdone) begin
            if (op_reg == `EEMC_CMD_READ) begin
              chip_enable_n <= 1'b0; // R4
              output_enable_n <= 1'b0; // R5 R14
              state_reg <= S_ACCESS;
            end else if (op_reg == `EEMC_CMD_ERASE) begin
              output_enable_n <= 1'b0; // R18
              state_reg <= S_PULSE;
            end else begin
              chip_enable_n <= 1'b0; // R18
              state_reg <= S_PULSE;
            end
          end
        end
        S_ACCESS: begin
          if (tdone) begin
            rsp_rdata <= din_sync_reg;
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            chip_select <= 1'b0;
            state_reg <= S_DONE;
          end
        end
        S_PULSE: begin
          if (tdone) begin
            chip_enable_n <= 1'b1; // R17
            output_enable_n <= 1'b1; // R17
            state_reg <= S_VPP_DN;
          end
        end
        S_VPP_DN: begin
          if (op_reg != `EEMC_CMD_READ && tdone) begin
            data_io_lines_oe <= 1'b0; // R9
            if (hold_reg) begin
              state_reg <= S_DONE; // R10
            end else begin
              vpp_enable <= 1'b0; // R11
              op_reg <= `EEMC_CMD_READ;
            end
          end else if (op_reg == `EEMC_CMD_READ) begin
            vpp_enable <= 1'b0; // R7 R11
            if (tdone || !vpp_enable) begin
              state_reg <= S_SETUP;
            end
          end
        end
        S_DONE: begin
          rsp_valid <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: bench/eemc_dev_model.sv
// Behavioural model of the 1024-byte EEPROM at the far side of the pins.
`timescale 1ns/1ps
`default_nettype none
module eemc_dev_model #(
  // Shortest strobe that completes an erase or a program.
  parameter int OP_NS = 1000000
) (
  // Device pins
  input wire logic [9:0] address_lines,
  input wire logic [7:0] data_in,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic chip_select,
  input wire logic vpp_enable,
  output logic [7:0] data_out,
  output logic data_oe
);
  logic [7:0] mem_reg [0:1023];
  logic [9:0] addr_reg;
  logic [7:0] latch_reg;
  realtime ce_fall_t;
  realtime oe_fall_t;
  always @(negedge chip_enable_n) begin
    addr_reg = address_lines;
    latch_reg = mem_reg[address_lines];
    ce_fall_t = $realtime;
  end
  always @(posedge chip_enable_n) begin
    if (vpp_enable && ($realtime - ce_fall_t) >= OP_NS)
      mem_reg[addr_reg] = mem_reg[addr_reg] | data_in;
  end
  always @(negedge output_enable_n) begin
    oe_fall_t = $realtime;
  end
  always @(posedge output_enable_n) begin
    if (vpp_enable && chip_enable_n && ($realtime - oe_fall_t) >= OP_NS)
      foreach (mem_reg[i]) mem_reg[i] = 8'h00;
  end
  // Released lines show the inverse of the latch.
  assign data_oe = !chip_enable_n && chip_select && !output_enable_n &&
    !vpp_enable;
  assign data_out = data_oe ? latch_reg : ~latch_reg;
endmodule
`default_nettype wire

// file: bench/eemc_host_asserts.sv
// Pin-side assertions of the EEPROM host controller.
`timescale 1ns/1ps
`default_nettype none
module eemc_host_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Device pins
  input wire logic [9:0] address_lines,
  input wire logic [7:0] data_io_lines_o,
  input wire logic data_io_lines_oe,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic chip_select,
  input wire logic vpp_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  no_both_low_a: assert property (
    vpp_enable |-> chip_enable_n || output_enable_n)
    else $error("Both enables low.");
  supply_standby_a: assert property (
    $changed(vpp_enable) |-> chip_enable_n && output_enable_n &&
    $past(chip_enable_n) && $past(output_enable_n))
    else $error("Supply moved outside standby.");
  erase_setup_a: assert property (
    $fell(output_enable_n) && vpp_enable |-> $past(vpp_enable, 3) &&
    chip_enable_n) else $error("Bad erase.");
  prog_setup_a: assert property (
    $fell(chip_enable_n) && vpp_enable |-> $past(vpp_enable, 3) &&
    output_enable_n) else $error("Bad prog.");
  data_setup_a: assert property (
    $fell(chip_enable_n) && vpp_enable |-> data_io_lines_oe &&
    $past(data_io_lines_oe)) else $error("Data late.");
  data_hold_a: assert property (
    vpp_enable && !chip_enable_n |=> chip_enable_n ||
    ($stable(data_io_lines_o) && data_io_lines_oe))
    else $error("Data moved.");
  addr_hold_a: assert property (
    !chip_enable_n |=> chip_enable_n || $stable(address_lines))
    else $error("Address moved.");
  host_drive_a: assert property (
    data_io_lines_oe |-> vpp_enable && output_enable_n)
    else $error("Host drove in read.");
  read_select_a: assert property (
    !chip_enable_n && chip_select |-> !vpp_enable && !data_io_lines_oe)
    else $error("Selected at supply.");
endmodule
bind eemc_host eemc_host_asserts i_eemc_host_asserts (.clk_sys(clk_sys),
  .rst_n(rst_n), .address_lines(address_lines),
  .data_io_lines_o(data_io_lines_o), .data_io_lines_oe(data_io_lines_oe),
  .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
  .chip_select(chip_select), .vpp_enable(vpp_enable));
`default_nettype wire

// file: bench/tb_eemc_host.sv
// Self-checking bench of the EEPROM host controller.
`timescale 1ns/1ps
`default_nettype none
`include "eemc_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_eemc_host;
  logic clk_sys, rst_n, cmd_valid, cmd_hold_vpp, cmd_ready, rsp_valid;
  logic [1:0] cmd_op;
  logic [9:0] cmd_addr, address_lines;
  logic [7:0] cmd_wdata, rsp_rdata, data_o, dev_out, data_i;
  logic data_oe, ce_n, oe_n, cs, vpp, dev_oe;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  assign data_i = data_oe ? data_o : dev_out;
  eemc_host #(.OP_CYC(20), .VPSU_CYC(4)) i_eemc_host (.clk_sys(clk_sys),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_hold_vpp(cmd_hold_vpp), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .address_lines(address_lines), .data_io_lines_i(data_i),
    .data_io_lines_o(data_o), .data_io_lines_oe(data_oe),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .chip_select(cs),
    .vpp_enable(vpp));
  eemc_dev_model #(.OP_NS(500)) i_eemc_dev_model (
    .address_lines(address_lines),
    .data_in(data_i), .chip_enable_n(ce_n), .output_enable_n(oe_n),
    .chip_select(cs), .vpp_enable(vpp), .data_out(dev_out),
    .data_oe(dev_oe));
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_cmd(input logic [1:0] op, input logic [9:0] a,
    input logic [7:0] d, input logic h);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_hold_vpp = h;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 500) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("rsp_valid", 1'b1, rsp_valid)
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    do_cmd(`EEMC_CMD_READ, a, 8'h00, 1'b0);
    `CHK("rsp_rdata", e, rsp_rdata)
  endtask
  task automatic t_erase();
    do_cmd(`EEMC_CMD_ERASE, 10'h000, 8'h00, 1'b0);
    rd(10'h000, 8'h00);
    rd(10'h3FF, 8'h00);
    $display("Erase test done");
  endtask
  task automatic t_prog();
    do_cmd(`EEMC_CMD_PROG, 10'h005, 8'h3C, 1'b0);
    do_cmd(`EEMC_CMD_PROG, 10'h005, 8'h81, 1'b0);
    do_cmd(`EEMC_CMD_PROG, 10'h005, 8'h00, 1'b0);
    rd(10'h005, 8'hBD);
    $display("Program test done");
  endtask
  task automatic t_hold();
    do_cmd(`EEMC_CMD_ERASE, 10'h000, 8'h00, 1'b1);
    do_cmd(`EEMC_CMD_PROG, 10'h3FF, 8'hA5, 1'b1);
    do_cmd(`EEMC_CMD_PROG, 10'h000, 8'h0F, 1'b1);
    rd(10'h3FF, 8'hA5);
    do_cmd(`EEMC_CMD_PROG, 10'h200, 8'h5A, 1'b1);
    do_cmd(`EEMC_CMD_PROG, 10'h200, 8'h81, 1'b0);
    rd(10'h000, 8'h0F);
    rd(10'h200, 8'hDB);
    rd(10'h005, 8'h00);
    $display("Held supply test done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    `CHK("bus_clash", 1'b0, data_oe & dev_oe)
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_hold_vpp = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 10'h000;
    cmd_wdata = 8'h00;
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("vpp_enable", 1'b0, vpp)
    t_erase();
    t_prog();
    t_hold();
    end_sim();
  end
endmodule
`default_nettype wire
